// ==== lock_detect_config_regs.sv ====
// Module: lock-detect and lock/serial-output pin configuration registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - The window code selects 5, 32, 96, 256, 512, 2048, 8192 or 65535 consecutive in-window counts.
// - Lock detection runs only while the enable bit is 1, which resets to 1.
// - Mode bit 0 selects manual lock detection and 1 automatic training, resetting to 0.
// - Only a 0-to-1 change of the training bit starts a training run.
// - Timer divide and speed fields take effect only in manual mode.
// - With the driver enable bit 0 the lock/serial-output pin is high impedance.
// - With driver enable 1 and pin-select 1 the pin is always driven, as general purpose output.
// - With driver enable 1 and pin-select 0 the pin is released unless the last chip address was 000.
// - Without synchronous mode writes apply at a later load strobe, else at a later internal tick; a write in the cycle of the strobe or tick is never applied.
module lock_detect_config_regs
    import lock_detect_config_pkg::*;
(
    input  wire logic                                    sys_clk,       // System clock
    input  wire logic                                    arst_n,        // Async reset, active low
    input  wire logic                                    clk_en,        // Freezes state when low
    input  wire logic                                    wr_valid,      // Shifted word ready
    input  wire logic [lock_detect_config_pkg::REG_ADDR_W-1:0] wr_addr, // Register address
    input  wire logic [lock_detect_config_pkg::REG_DATA_W-1:0] wr_data, // Register data
    input  wire logic [lock_detect_config_pkg::CHIP_ADDR_W-1:0] rx_chip_addr, // Received chip addr
    input  wire logic                                    serial_load_strobe, // Load strobe
    input  wire logic                                    sync_mode,     // Synchronous load mode
    input  wire logic                                    internal_tick, // Internal clock tick
    input  wire logic                                    pin_select,    // Pin-select bit, reg 0Fh
    input  wire logic                                    lock_indicator_in, // Raw lock state
    input  wire logic                                    serial_data_in,    // Serial read data
    output logic [lock_detect_config_pkg::REG_DATA_W-1:0] lock_ctrl_q,  // Applied control reg
    output logic [lock_detect_config_pkg::REG_DATA_W-1:0] analog_en_q,  // Applied analog reg
    output lock_detect_config_pkg::lock_cfg_t            lock_cfg,      // Decoded lock settings
    output logic                                         lock_or_serial_out_pin_o,  // Pin out
    output logic                                         lock_or_serial_out_pin_oe  // Pin drive
);
    import lock_detect_config_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [REG_DATA_W-1:0]  shd_lock;
        logic [REG_DATA_W-1:0]  shd_analog;
        logic                   pend_lock;
        logic                   pend_analog;
        logic [REG_DATA_W-1:0]  lock_ctrl;
        logic [REG_DATA_W-1:0]  analog_en;
        logic [CHIP_ADDR_W-1:0] last_chip;
        lock_cfg_t              cfg;
        pin_drive_t             pin;
    } state_t;

    localparam state_t STATE_RST = '{
        shd_lock:    LOCK_CTRL_RST,
        shd_analog:  ANALOG_EN_RST,
        pend_lock:   1'b0,
        pend_analog: 1'b0,
        lock_ctrl:   LOCK_CTRL_RST,
        analog_en:   ANALOG_EN_RST,
        last_chip:   SHARED_CHIP_ADDR,
        cfg:         '0,
        pin:         '0
    };

    state_t state_ff;
    state_t nxt_state;

    logic [REG_DATA_W-1:0] new_lock;
    logic [REG_DATA_W-1:0] new_analog;
    logic                  apply_now;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (REG_DATA_W <= TRAIN_BIT || REG_DATA_W <= HF_REF_BIT) begin : g_bad_data_w
        $error("Register width too narrow for the field layout");
    end

    if (CHIP_ADDR_W != $bits(SHARED_CHIP_ADDR)) begin : g_bad_chip_w
        $error("Chip address width does not match the shared address");
    end

    if (REG_ADDR_W != $bits(LOCK_CTRL_ADDR)) begin : g_bad_addr_w
        $error("Register address width does not match the register map");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Write word aimed at the given register
    function automatic logic hits(
        input logic                  valid,
        input logic [REG_ADDR_W-1:0] addr,
        input logic [REG_ADDR_W-1:0] target
    );
        hits = valid && (addr == target);
    endfunction : hits

    // Pin drive from the applied enable, pin mode and last chip address
    function automatic pin_drive_t pin_drive_of(
        input logic                   drv_en,
        input logic                   gpo_sel,
        input logic [CHIP_ADDR_W-1:0] chip,
        input logic                   lock_val,
        input logic                   sdo_val
    );
        pin_drive_t pin;
        pin.pin_out = gpo_sel ? lock_val : sdo_val;
        if (!drv_en) begin
            pin.pin_oe = 1'b0;
        end else if (gpo_sel) begin
            pin.pin_oe = 1'b1;
        end else begin
            pin.pin_oe = (chip == SHARED_CHIP_ADDR);
        end
        pin_drive_of = pin;
    endfunction : pin_drive_of

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (wr_valid) begin
            nxt_state.last_chip = rx_chip_addr;
        end
        if (hits(wr_valid, wr_addr, LOCK_CTRL_ADDR)) begin
            nxt_state.shd_lock  = wr_data;
            nxt_state.pend_lock = 1'b1;
        end
        if (hits(wr_valid, wr_addr, ANALOG_EN_ADDR)) begin
            nxt_state.shd_analog  = wr_data;
            nxt_state.pend_analog = 1'b1;
        end
        // Apply on strobe, or on internal tick in synchronous mode
        apply_now = sync_mode ? internal_tick : serial_load_strobe;
        new_lock   = state_ff.lock_ctrl;
        new_analog = state_ff.analog_en;
        if (apply_now) begin
            if (state_ff.pend_lock) begin
                new_lock = state_ff.shd_lock;
            end
            if (state_ff.pend_analog) begin
                new_analog = state_ff.shd_analog;
            end
            nxt_state.pend_lock   = 1'b0;
            nxt_state.pend_analog = 1'b0;
        end
        nxt_state.lock_ctrl = new_lock;
        nxt_state.analog_en = new_analog;

        // Decoded configuration
        nxt_state.cfg.win_code  = new_lock[WINCNT_LSB +: 3];
        nxt_state.cfg.win_count = win_count_of(new_lock[WINCNT_LSB +: 3]);
        nxt_state.cfg.ld_enable = new_lock[LD_EN_BIT];
        nxt_state.cfg.ld_mode   = ld_mode_t'(new_lock[LD_MODE_BIT]);
        if (new_lock[LD_MODE_BIT] == LD_MANUAL) begin
            nxt_state.cfg.tmr_div = new_lock[TMR_DIV_LSB +: 3];
            nxt_state.cfg.tmr_spd = new_lock[TMR_SPD_LSB +: 2];
        end else begin
            nxt_state.cfg.tmr_div = '0;
            nxt_state.cfg.tmr_spd = '0;
        end
        // Training only on a rising edge of the applied bit
        nxt_state.cfg.train_pulse = new_lock[TRAIN_BIT] &
                                    ~state_ff.lock_ctrl[TRAIN_BIT] &
                                    new_lock[LD_EN_BIT];
        nxt_state.cfg.hf_ref = new_analog[HF_REF_BIT];

        // Lock/serial-output pin drive
        nxt_state.pin = pin_drive_of(new_analog[DRV_EN_BIT],
                                     pin_select,
                                     nxt_state.last_chip,
                                     lock_indicator_in,
                                     serial_data_in);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= STATE_RST;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign lock_ctrl_q               = state_ff.lock_ctrl;
    assign analog_en_q               = state_ff.analog_en;
    assign lock_cfg                  = state_ff.cfg;
    assign lock_or_serial_out_pin_o  = state_ff.pin.pin_out;
    assign lock_or_serial_out_pin_oe = state_ff.pin.pin_oe;
endmodule : lock_detect_config_regs

`default_nettype wire

// ==== lock_detect_config_pkg.sv ====
// Package: register map, field layout and types of the lock-detect configuration bank
package lock_detect_config_pkg;
    localparam int          REG_ADDR_W      = 6;
    localparam int          REG_DATA_W      = 24;
    localparam int          CHIP_ADDR_W     = 3;
    localparam logic [5:0]  LOCK_CTRL_ADDR  = 6'h07;
    localparam logic [5:0]  ANALOG_EN_ADDR  = 6'h08;
    localparam logic [23:0] LOCK_CTRL_RST   = 24'h200844;
    localparam logic [23:0] ANALOG_EN_RST   = 24'h01BFFF;
    localparam logic [2:0]  SHARED_CHIP_ADDR = 3'h0;
    // Field positions of lock_detect_control
    localparam int WINCNT_LSB    = 0;
    localparam int TMR_DIV_LSB   = 5;
    localparam int TMR_SPD_LSB   = 8;
    localparam int LD_EN_BIT     = 11;
    localparam int LD_MODE_BIT   = 14;
    localparam int TRAIN_BIT     = 20;
    // Field positions of analog_enable_control
    localparam int DRV_EN_BIT    = 5;
    localparam int HF_REF_BIT    = 21;
    // Field position of the synchronous-load control, and width of the window count
    localparam int SYNC_MODE_BIT = 4;
    localparam int WIN_CNT_W     = 17;

    typedef enum logic [0:0] {
        LD_MANUAL = 1'b0,
        LD_AUTO   = 1'b1
    } ld_mode_t;

    typedef struct packed {
        logic [2:0] win_code;
        logic [2:0] tmr_div;
        logic [1:0] tmr_spd;
        logic       ld_enable;
        ld_mode_t   ld_mode;
        logic       train_pulse;
        logic       hf_ref;
        logic [16:0] win_count;
    } lock_cfg_t;

    typedef struct packed {
        logic       pin_out;
        logic       pin_oe;
    } pin_drive_t;

    function automatic logic [16:0] win_count_of(input logic [2:0] code);
        unique case (code)
            3'h0: win_count_of = 17'h00005;
            3'h1: win_count_of = 17'h00020;
            3'h2: win_count_of = 17'h00060;
            3'h3: win_count_of = 17'h00100;
            3'h4: win_count_of = 17'h00200;
            3'h5: win_count_of = 17'h00800;
            3'h6: win_count_of = 17'h02000;
            3'h7: win_count_of = 17'h0FFFF;
        endcase
    endfunction : win_count_of
endpackage : lock_detect_config_pkg

// ==== ldc_checker.sv ====
// Checker: assertions on the lock-detect configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module ldc_checker
    import lock_detect_config_pkg::*;
(
    input wire logic        sys_clk,            // Clock
    input wire logic        arst_n,             // Reset
    input wire logic        clk_en,             // Advance
    input wire logic        wr_valid,           // Word
    input wire logic [2:0]  rx_chip_addr,       // Chip
    input wire logic        serial_load_strobe, // Load
    input wire logic        sync_mode,          // Sync
    input wire logic        internal_tick,      // Tick
    input wire logic        pin_select,         // Pin mode
    input wire logic [23:0] lock_ctrl_q,        // Lock reg
    input wire logic [23:0] analog_en_q,        // Analog reg
    input wire lock_detect_config_pkg::lock_cfg_t lock_cfg, // Decoded
    input wire logic        lock_or_serial_out_pin_oe // Drive
);
    localparam logic [16:0] WC [8] = '{17'h00005, 17'h00020, 17'h00060, 17'h00100,
                                       17'h00200, 17'h00800, 17'h02000, 17'h0FFFF};
    logic [2:0] last_ff;
    logic       apl;
    assign apl = clk_en && (sync_mode ? internal_tick : serial_load_strobe);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) last_ff <= 3'h0;
        else if (clk_en && wr_valid) last_ff <= rx_chip_addr;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_st; (clk_en && $stable(lock_ctrl_q))[*3]; endsequence
    sequence s_pin;
        (clk_en && $stable(analog_en_q) && $stable(last_ff) && $stable(pin_select))[*3];
    endsequence
    property p_win; s_st |-> lock_cfg.win_count == WC[lock_ctrl_q[2:0]]; endproperty
    a_win: assert property (p_win) else $error("window count wrong");
    property p_en; s_st |-> lock_cfg.ld_enable == lock_ctrl_q[11]; endproperty
    a_en: assert property (p_en) else $error("enable wrong");
    property p_mode; s_st |-> lock_cfg.ld_mode == ld_mode_t'(lock_ctrl_q[14]); endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_tmr;
        s_st |-> {lock_cfg.tmr_div, lock_cfg.tmr_spd} ==
                 (lock_ctrl_q[14] ? 5'h00 : {lock_ctrl_q[7:5], lock_ctrl_q[9:8]});
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer fields wrong");
    property p_trn; lock_cfg.train_pulse |-> $rose(lock_ctrl_q[20]) && lock_ctrl_q[11]; endproperty
    a_trn: assert property (p_trn) else $error("spurious training");
    property p_off; s_pin ##0 !analog_en_q[5] |-> !lock_or_serial_out_pin_oe; endproperty
    a_off: assert property (p_off) else $error("pin driven while off");
    property p_gpo; s_pin ##0 (analog_en_q[5] && pin_select) |-> lock_or_serial_out_pin_oe; endproperty
    a_gpo: assert property (p_gpo) else $error("pin not driven");
    property p_shr; s_pin ##0 (analog_en_q[5] && !pin_select) |-> lock_or_serial_out_pin_oe == (last_ff == 3'h0); endproperty
    a_shr: assert property (p_shr) else $error("shared pin wrong");
    property p_apl; $changed(lock_ctrl_q) |-> $past(apl); endproperty
    a_apl: assert property (p_apl) else $error("register changed without apply");
    c_trn: cover property (lock_cfg.train_pulse);
    c_gpo: cover property (s_pin ##0 (analog_en_q[5] && pin_select));
    c_shr: cover property (s_pin ##0 (analog_en_q[5] && !pin_select && last_ff != 3'h0));
endmodule : ldc_checker
bind lock_detect_config_regs ldc_checker i_ldc_checker (.*);
`default_nettype wire

// ==== ser_host.sv ====
// Partner: serial host model writing and loading configuration words
`timescale 1ns/1ps
`default_nettype none
module ser_host (
    input  wire logic        sys_clk,            // Clock
    output logic             wr_valid,           // Word ready
    output logic [5:0]       wr_addr,            // Address
    output logic [23:0]      wr_data,            // Data
    output logic [2:0]       rx_chip_addr,       // Chip
    output logic             serial_load_strobe, // Load
    output logic             internal_tick       // Tick
);
    initial {wr_valid, wr_addr, wr_data, rx_chip_addr, serial_load_strobe, internal_tick} = '0;
    task wr(input logic [5:0] a, input logic [23:0] d, input logic [2:0] c);
        @(posedge sys_clk) {wr_valid, wr_addr, wr_data, rx_chip_addr} <= {1'b1, a, d, c};
        @(posedge sys_clk) {wr_valid, wr_addr, wr_data} <= {1'b0, ~a, ~d};
    endtask : wr
    task apply(input logic tk);
        @(posedge sys_clk) {serial_load_strobe, internal_tick} <= {!tk, tk};
        @(posedge sys_clk) {serial_load_strobe, internal_tick} <= 2'h0;
    endtask : apply
    task retrain(input logic [23:0] d);
        wr(6'h07, d & 24'hEFFFFF, 3'h0);
        apply(1'b0);
        wr(6'h07, d | 24'h100000, 3'h0);
        apply(1'b0);
    endtask : retrain
endmodule : ser_host
`default_nettype wire

// ==== tb.sv ====
// Testbench: random and corner scenarios for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lock_detect_config_pkg::*;
    localparam logic [16:0] WC [8] = '{17'h00005, 17'h00020, 17'h00060, 17'h00100,
                                       17'h00200, 17'h00800, 17'h02000, 17'h0FFFF};
    localparam int REF_MHZ = 100;
    logic sys_clk, arst_n, clk_en, sync_mode, pin_select, lock_indicator_in, serial_data_in;
    logic wr_valid, serial_load_strobe, internal_tick, lock_or_serial_out_pin_o, lock_or_serial_out_pin_oe;
    logic [5:0] wr_addr;
    logic [2:0] rx_chip_addr;
    logic [23:0] wr_data, lock_ctrl_q, analog_en_q;
    lock_cfg_t lock_cfg;
    int miscompares, checks;
    lock_detect_config_regs i_lock_detect_config_regs (.*);
    ser_host i_ser_host (.*);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task chk(input logic [23:0] s, input logic [23:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task report_and_stop;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    function automatic logic [23:0] mk_lock(logic [2:0] wc, logic [2:0] dv, logic [1:0] sp, logic en, logic md, logic tr);
        return 24'h200000 | {tr, 5'h00, md, 2'h0, en, 1'b0, sp, dv, 2'h0, wc};
    endfunction : mk_lock
    function automatic logic [23:0] mk_an(logic dr);
        return 24'h01BFDF | {2'h0, REF_MHZ > 200, 15'h0000, dr, 5'h00};
    endfunction : mk_an
    task settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle
    initial begin
        logic [23:0] r, w, an;
        logic [2:0]  c;
        void'($urandom(7053));
        {arst_n, clk_en, sync_mode, pin_select, lock_indicator_in, serial_data_in} = 6'h11;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1 chk(lock_ctrl_q, 24'h200844);
        chk(analog_en_q, 24'h01BFFF);
        settle;
        chk(lock_cfg.win_count, 17'h00200);
        chk(lock_cfg.ld_enable, 1'b1);
        chk(lock_or_serial_out_pin_oe, 1'b1);
        repeat (24) begin
            r = $urandom;
            w = mk_lock(r[2:0], r[5:3], r[7:6], r[8], r[9], 1'b0);
            an = mk_an(r[10]);
            c = r[13:11] & {3{r[14]}};
            i_ser_host.wr(6'h07, w, 3'h0);
            i_ser_host.wr(6'h08, an, c);
            {pin_select, lock_indicator_in, serial_data_in} <= r[17:15];
            i_ser_host.apply(1'b0);
            settle;
            chk(lock_ctrl_q, w);
            chk(lock_cfg.win_count, WC[r[2:0]]);
            chk(lock_cfg.ld_enable, r[8]);
            chk(lock_cfg.ld_mode, r[9]);
            chk({lock_cfg.tmr_div, lock_cfg.tmr_spd}, r[9] ? 5'h00 : {r[5:3], r[7:6]});
            chk(lock_cfg.win_code, r[2:0]);
            chk(lock_cfg.hf_ref, REF_MHZ > 200);
            chk(lock_or_serial_out_pin_oe, r[10] && (r[17] || c == 3'h0));
            chk(lock_or_serial_out_pin_o, r[17] ? r[16] : r[15]);
        end
        w = mk_lock(3'h7, 3'h4, 2'h0, 1'b1, 1'b0, 1'b1);
        i_ser_host.retrain(w);
        #1 chk(lock_cfg.train_pulse, 1'b1);
        i_ser_host.wr(6'h07, w, 3'h0);
        i_ser_host.apply(1'b0);
        #1 chk(lock_cfg.train_pulse, 1'b0);
        i_ser_host.wr(6'h0A, 24'h000000, 3'h0);
        i_ser_host.wr(6'h07, 24'h200844, 3'h0);
        settle;
        chk(lock_ctrl_q, w);
        sync_mode <= 1'b1;
        i_ser_host.apply(1'b0);
        settle;
        chk(lock_ctrl_q, w);
        i_ser_host.apply(1'b1);
        settle;
        chk(lock_ctrl_q, 24'h200844);
        chk(analog_en_q, an);
        report_and_stop;
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
